// File: hdl/alu_flag_pkg.sv
package alu_flag_pkg;

  localparam int data_w = 8;

  // operation select, one-hot
  typedef enum logic [8:0] {
    op_none                       = 9'h001,
    op_add_with_carry             = 9'h002,
    op_subtract_with_borrow       = 9'h004,
    op_product                    = 9'h008,
    op_quotient                   = 9'h010,
    op_decimal_adjust             = 9'h020,
    op_rotate_right_through_carry = 9'h040,
    op_rotate_left_through_carry  = 9'h080,
    op_compare_jump_not_equal     = 9'h100
  } alu_op_e;

  // decimal adjust constants, then the product limit and the zero byte
  localparam logic [7:0] da_low_fix = 8'h06;
  localparam logic [7:0] da_high_fix = 8'h60;
  localparam logic [8:0] da_bcd_max = 9'h099;
  localparam logic [3:0] da_nibble_max = 4'h9;
  localparam logic [15:0] byte_max = 16'h00ff;
  localparam logic [7:0] zero_byte = 8'h00;

  typedef struct packed {
    logic carry;
    logic half_carry_flag;
    logic signed_range_exceeded_flag;
  } flags_s;

  localparam flags_s flags_reset = '{carry: 1'b0, half_carry_flag: 1'b0,
                                     signed_range_exceeded_flag: 1'b0};

  typedef struct packed {
    alu_op_e op;
    logic [7:0] working_in;
    logic [7:0] source;
    logic [7:0] operand_b;
    logic [7:0] dest;
  } alu_req_s;

endpackage

// File: hdl/mcu_alu_flag_logic.sv
// Operation
// - add_with_carry: working plus source plus carry
// - add_with_carry carry out of bit 7
// - add_with_carry overflow: carry6 xor carry7
// - add_with_carry half carry from bit 3
// - subtract_with_borrow: working minus source minus borrow
// - subtract_with_borrow carry on borrow out of bit 7
// - subtract_with_borrow overflow: borrow6 xor borrow7
// - subtract_with_borrow half carry on bit 3 borrow
// - multiply: low to working, high to operand
// - multiply clears carry, overflow if above 255
// - divide: quotient to working, remainder operand
// - divide clears carry, overflow on zero divisor
// - adjust adds 06 if half carry/nibble>9
// - adjust adds 60 if carry or step one
// - adjust carry set when result exceeds 99
// - rotate right: bit0 to carry, carry in
// - rotate left: bit7 to carry, carry in
// - compare jump taken when values differ
// - compare carry when source above destination
module mcu_alu_flag_logic (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // request from the decoder
  input wire logic op_valid,
  input alu_flag_pkg::alu_req_s req,
  // flag load from other instructions
  input wire logic flags_load,
  input alu_flag_pkg::flags_s flags_in,
  // results
  output logic done_reg,
  output logic [7:0] working_out_reg,
  output logic working_we_reg,
  output logic [7:0] operand_b_out_reg,
  output logic operand_b_we_reg,
  output logic branch_taken_reg,
  output alu_flag_pkg::flags_s flags_reg
);

  alu_flag_pkg::flags_s flags_next;
  logic [7:0] working_next;
  logic [7:0] operand_b_next;
  logic working_we_next;
  logic operand_b_we_next;
  logic branch_next;

  wire logic cy = flags_reg.carry;
  wire logic [7:0] a = req.working_in;
  wire logic [7:0] s = req.source;
  wire logic [7:0] b = req.operand_b;

  // one ripple stage per bit, so the carry and borrow out of every bit can be tapped
  wire logic [8:0] add_carry;
  wire logic [8:0] sub_borrow;
  wire logic [7:0] add_sum;
  wire logic [7:0] sub_diff;

  assign add_carry[0] = cy;
  assign sub_borrow[0] = cy;

  for (genvar i = 0; i < 8; i++) begin : g_bit
    wire logic differ = a[i] ^ s[i];
    assign add_sum[i] = differ ^ add_carry[i];
    assign add_carry[i + 1] = (a[i] & s[i]) | (differ & add_carry[i]);
    assign sub_diff[i] = differ ^ sub_borrow[i];
    assign sub_borrow[i + 1] = (~a[i] & s[i]) | (~differ & sub_borrow[i]);
  end

  wire logic add_c7 = add_carry[8];
  wire logic add_c6 = add_carry[7];
  wire logic add_c3 = add_carry[4];
  wire logic sub_b7 = sub_borrow[8];
  wire logic sub_b6 = sub_borrow[7];
  wire logic sub_b3 = sub_borrow[4];

  // multiply, single cycle
  wire logic [15:0] product = {8'h00, a} * {8'h00, b};
  wire logic product_big = product > alu_flag_pkg::byte_max;

  // divide; a zero divisor leaves results undefined, guarded to keep x out
  wire logic div_zero = b == alu_flag_pkg::zero_byte;
  wire logic [7:0] quotient = div_zero ? a : a / b;
  wire logic [7:0] remainder = div_zero ? b : a % b;

  // decimal adjust; carry follows the final compare only, a prior carry is not kept
  wire logic da_step1 = flags_reg.half_carry_flag || (a[3:0] > alu_flag_pkg::da_nibble_max);
  wire logic [8:0] da_sum1 = {1'b0, a} + (da_step1 ? {1'b0, alu_flag_pkg::da_low_fix} : 9'h000);
  wire logic da_step2 = cy || da_step1;
  wire logic [8:0] da_sum2 = da_sum1 + (da_step2 ? {1'b0, alu_flag_pkg::da_high_fix} : 9'h000);
  wire logic da_carry = da_sum2 > alu_flag_pkg::da_bcd_max;

  // compare jump
  wire logic cmp_ne = s != req.dest;
  wire logic cmp_gt = s > req.dest;

  always_comb begin
    flags_next = flags_reg;
    working_next = working_out_reg;
    operand_b_next = operand_b_out_reg;
    working_we_next = 1'b0;
    operand_b_we_next = 1'b0;
    branch_next = 1'b0;
    if (op_valid) begin
      case (req.op)
        alu_flag_pkg::op_add_with_carry: begin
          working_next = add_sum;
          working_we_next = 1'b1;
          flags_next.carry = add_c7;
          flags_next.signed_range_exceeded_flag = add_c6 ^ add_c7;
          flags_next.half_carry_flag = add_c3;
        end
        alu_flag_pkg::op_subtract_with_borrow: begin
          working_next = sub_diff;
          working_we_next = 1'b1;
          flags_next.carry = sub_b7;
          flags_next.signed_range_exceeded_flag = sub_b6 ^ sub_b7;
          flags_next.half_carry_flag = sub_b3;
        end
        alu_flag_pkg::op_product: begin
          working_next = product[7:0];
          operand_b_next = product[15:8];
          working_we_next = 1'b1;
          operand_b_we_next = 1'b1;
          flags_next.carry = 1'b0;
          flags_next.signed_range_exceeded_flag = product_big;
        end
        alu_flag_pkg::op_quotient: begin
          working_next = quotient;
          operand_b_next = remainder;
          working_we_next = 1'b1;
          operand_b_we_next = 1'b1;
          flags_next.carry = 1'b0;
          flags_next.signed_range_exceeded_flag = div_zero;
        end
        alu_flag_pkg::op_decimal_adjust: begin
          working_next = da_sum2[7:0];
          working_we_next = 1'b1;
          flags_next.carry = da_carry;
        end
        alu_flag_pkg::op_rotate_right_through_carry: begin
          working_next = {cy, a[7:1]};
          working_we_next = 1'b1;
          flags_next.carry = a[0];
        end
        alu_flag_pkg::op_rotate_left_through_carry: begin
          working_next = {a[6:0], cy};
          working_we_next = 1'b1;
          flags_next.carry = a[7];
        end
        alu_flag_pkg::op_compare_jump_not_equal: begin
          branch_next = cmp_ne;
          flags_next.carry = cmp_gt;
        end
        default: begin
          flags_next = flags_reg;
        end
      endcase
    end else if (flags_load) begin
      flags_next = flags_in;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      flags_reg <= alu_flag_pkg::flags_reset;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // result registers hold between writes; the write strobes say when to use them
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      working_out_reg <= alu_flag_pkg::zero_byte;
    end else begin
      working_out_reg <= working_next;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      operand_b_out_reg <= alu_flag_pkg::zero_byte;
    end else begin
      operand_b_out_reg <= operand_b_next;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      working_we_reg <= 1'b0;
    end else begin
      working_we_reg <= working_we_next;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      operand_b_we_reg <= 1'b0;
    end else begin
      operand_b_we_reg <= operand_b_we_next;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      branch_taken_reg <= 1'b0;
    end else begin
      branch_taken_reg <= branch_next;
    end
  end

  // done pulses for refused codes too, so the decoder never waits on a bad op
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= op_valid;
    end
  end

endmodule

// File: testbench/alu_chk_sva.sv
module alu_chk (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic op_valid,
  input alu_flag_pkg::alu_req_s req,
  input wire logic flags_load,
  input wire logic done_reg,
  input wire logic [7:0] working_out_reg,
  input wire logic [7:0] operand_b_out_reg,
  input wire logic branch_taken_reg,
  input alu_flag_pkg::flags_s flags_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire [8:0] add9 = req.working_in + req.source + flags_reg.carry;
  wire [8:0] sub9 = req.working_in - req.source - flags_reg.carry;
  wire [15:0] prd = req.working_in * req.operand_b;
  wire ne = req.source != req.dest;
  wire gt = req.source > req.dest;
  sequence s_go(logic [8:0] o);
    op_valid && req.op == o;
  endsequence
  property p_done; op_valid |=> done_reg; endproperty
  a_done: assert property (p_done) else $error("no done");
  property p_add; s_go(9'h002) |=> {flags_reg.carry, working_out_reg} == $past(add9); endproperty
  a_add: assert property (p_add) else $error("add");
  property p_sub; s_go(9'h004) |=> {flags_reg.carry, working_out_reg} == $past(sub9); endproperty
  a_sub: assert property (p_sub) else $error("sub");
  property p_mul; s_go(9'h008) |=> {operand_b_out_reg, working_out_reg} == $past(prd)
    && !flags_reg.carry && flags_reg.signed_range_exceeded_flag == ($past(prd) > 16'h00ff);
  endproperty
  a_mul: assert property (p_mul) else $error("product");
  property p_dz; s_go(9'h010) and req.operand_b == 8'h00 |=> !flags_reg.carry
    && flags_reg.signed_range_exceeded_flag; endproperty
  a_dz: assert property (p_dz) else $error("zero divisor");
  property p_rr; s_go(9'h040) |=> {working_out_reg, flags_reg.carry}
    == {$past(flags_reg.carry), $past(req.working_in)}; endproperty
  a_rr: assert property (p_rr) else $error("rotate right");
  property p_rl; s_go(9'h080) |=> {flags_reg.carry, working_out_reg}
    == {$past(req.working_in), $past(flags_reg.carry)}; endproperty
  a_rl: assert property (p_rl) else $error("rotate left");
  property p_cj; s_go(9'h100) |=> branch_taken_reg == $past(ne) && flags_reg.carry == $past(gt);
  endproperty
  a_cj: assert property (p_cj) else $error("compare jump");
  property p_hold; !op_valid && !flags_load |=> $stable(flags_reg); endproperty
  a_hold: assert property (p_hold) else $error("flags moved");
endmodule
bind mcu_alu_flag_logic alu_chk u_chk (
  .clk_sys(clk_sys),
  .sys_rst(sys_rst),
  .op_valid(op_valid),
  .req(req),
  .flags_load(flags_load),
  .done_reg(done_reg),
  .working_out_reg(working_out_reg),
  .operand_b_out_reg(operand_b_out_reg),
  .branch_taken_reg(branch_taken_reg),
  .flags_reg(flags_reg)
);

// File: testbench/mcu_alu_flag_logic_test.sv
module mcu_alu_flag_logic_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, sys_rst = 1, op_valid = 0, flags_load = 0;
  alu_flag_pkg::alu_req_s req = '0;
  alu_flag_pkg::flags_s flags_in = '0, fm = '0, flags_reg;
  logic done_reg, working_we_reg, operand_b_we_reg, branch_taken_reg;
  logic [7:0] working_out_reg, operand_b_out_reg, a, s;
  logic [21:0] q[$];
  logic [21:0] e;
  int errors = 0, n_checks = 0, cyc = 0;
  always #2 clk_sys = ~clk_sys;
  mcu_alu_flag_logic u_dut (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .op_valid(op_valid),
    .req(req),
    .flags_load(flags_load),
    .flags_in(flags_in),
    .done_reg(done_reg),
    .working_out_reg(working_out_reg),
    .working_we_reg(working_we_reg),
    .operand_b_out_reg(operand_b_out_reg),
    .operand_b_we_reg(operand_b_we_reg),
    .branch_taken_reg(branch_taken_reg),
    .flags_reg(flags_reg)
  );
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic go(input logic [8:0] o, input logic [7:0] a, s, b, d);
    logic [8:0] t;
    logic [15:0] p;
    logic [7:0] w, r;
    logic c, h, v, we, bw, br, k;
    {c, h, v} = fm;
    {we, bw, br, w, r} = '0;
    case (o)
      9'h002: begin
        t = a + s + c;
        h = ({1'b0, a[3:0]} + s[3:0] + c) > 5'h0f;
        v = (a[7] ~^ s[7]) & (t[7] ^ a[7]);
        {we, c, w} = {1'b1, t};
      end
      9'h004: begin
        t = a - s - c;
        h = {1'b0, a[3:0]} < s[3:0] + c;
        v = (a[7] ^ s[7]) & (t[7] ^ a[7]);
        {we, c, w} = {1'b1, t};
      end
      9'h008: begin
        p = a * b;
        {r, w, v, c, we, bw} = {p, p > 16'h00ff, 3'b011};
      end
      9'h010: begin
        v = b == 8'h00;
        w = v ? a : a / b;
        r = v ? b : a % b;
        {c, we, bw} = 3'b011;
      end
      9'h020: begin
        k = h || a[3:0] > 4'h9;
        t = a + (k ? 9'h006 : 9'h000) + ((c || k) ? 9'h060 : 9'h000);
        {we, c, w} = {1'b1, t > 9'h099, t[7:0]};
      end
      9'h040: {we, w, c} = {1'b1, c, a};
      9'h080: {we, c, w} = {1'b1, a, c};
      9'h100: {br, c} = {s != d, s > d};
      default: ;
    endcase
    q.push_back({w, r, we, bw, br, c, h, v});
    fm = {c, h, v};
    req = {o, a, s, b, d};
    op_valid = 1;
    flags_load = 1'($urandom);
    flags_in = 3'($urandom);
    @(posedge clk_sys);
    #1;
  endtask
  // outputs are looked at mid-cycle, well clear of the edge that launches them
  always @(negedge clk_sys) begin
    if (++cyc > 2000) begin
      errors++;
      stop_test();
    end
    if (done_reg) begin
      e = q.pop_front();
      chk({2'b00, working_we_reg, operand_b_we_reg, branch_taken_reg, flags_reg},
          {2'b00, e[5:0]});
      if (e[5]) chk(working_out_reg, e[21:14]);
      if (e[4]) chk(operand_b_out_reg, e[13:6]);
    end
  end
  initial begin
    void'($urandom(45171));
    repeat (8) @(posedge clk_sys);
    #1;
    sys_rst = 0;
    for (int i = 0; i < 600; i++) begin
      a = 8'($urandom);
      s = 8'($urandom);
      if (i % 9 == 0) begin
        {op_valid, flags_load, flags_in} = {2'b01, 3'($urandom)};
        fm = flags_in;
        @(posedge clk_sys);
        #1;
      end
      go(i % 50 ? 9'h001 << ($urandom % 9) : 9'h003, a, s, i % 4 ? 8'($urandom) : 8'h00,
         i % 3 ? 8'($urandom) : s);
    end
    {op_valid, flags_load} = 2'b00;
    repeat (3) @(posedge clk_sys);
    chk(8'(q.size()), 8'h00);
    stop_test();
  end
endmodule
